// >>> bench/pixel_capture.sv
/*
  Downstream capture model: takes port A on a high pixel clock,
  port B on a low one. Assumes the core clock drives capture.
*/
`default_nettype none

module pixel_capture (
  input wire logic core_clk,
  input wire logic output_pixel_clock,
  input wire logic [7:0] red_a,
  input wire logic [7:0] green_a,
  input wire logic [7:0] blue_a,
  input wire logic [7:0] red_b,
  input wire logic [7:0] green_b,
  input wire logic [7:0] blue_b,
  output logic [7:0] cap_red,
  output logic [7:0] cap_green,
  output logic [7:0] cap_blue
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    cap_red <= output_pixel_clock ? red_a : red_b;
    cap_green <= output_pixel_clock ? green_a : green_b;
    cap_blue <= output_pixel_clock ? blue_a : blue_b;
  end
endmodule : pixel_capture

`default_nettype wire

// >>> bench/sdof_asserts.sv
/*
  Checker for the sync detect and output format block.
  Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none

module sdof_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic vsync_pin,
  input wire logic separator_vsync,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic [7:0] red_a,
  input wire logic [7:0] green_a,
  input wire logic [7:0] blue_a,
  input wire logic [7:0] red_b,
  input wire logic output_pixel_clock,
  input wire logic vertical_sync_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dual_r;
  logic yuv_r;
  logic [1:0] vsel_r;
  logic [2:0] quiet_r;
  wire settled = quiet_r == 3'h7;

  // Shadow of the written mode bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dual_r <= 1'b1;
      yuv_r <= 1'b0;
      vsel_r <= 2'h0;
      quiet_r <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == sync_fmt_pkg::ADDR_OUTPUT_FORMAT_CONFIG) begin
        dual_r <= reg_wdata[7];
        yuv_r <= reg_wdata[4];
      end
      if (reg_wr && reg_addr == sync_fmt_pkg::ADDR_SOURCE_OVERRIDE) begin
        vsel_r <= reg_wdata[1:0];
      end
      quiet_r <= reg_wr ? 3'h0 : (settled ? quiet_r : quiet_r + 3'h1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence a_take_s;
    output_pixel_clock && red_a == $past(red_in);
  endsequence
  sequence b_take_s;
    !output_pixel_clock && red_b == $past(red_in) && $stable(red_a);
  endsequence

  dual_clk_a: assert property (
    settled && dual_r |-> $changed(output_pixel_clock))
    else $error("pixel clock not at half rate");
  dual_pair_a: assert property (
    settled && dual_r && !yuv_r && output_pixel_clock |-> a_take_s ##1 b_take_s)
    else $error("dual port pairing broken");
  single_clk_a: assert property (
    settled && !dual_r |-> output_pixel_clock)
    else $error("single mode clock not high");
  single_b_a: assert property (
    settled && !dual_r |-> red_b == 8'h00)
    else $error("port B active in single mode");
  normal_path_a: assert property (
    settled && !dual_r && !yuv_r |-> red_a == $past(red_in)
      && green_a == $past(green_in) && blue_a == $past(blue_in))
    else $error("normal format path wrong");
  yuv_path_a: assert property (
    settled && !dual_r && yuv_r |-> green_a == $past(green_in)
      && blue_a == 8'h00
      && (red_a == $past(red_in) || red_a == $past(blue_in)))
    else $error("4:2:2 channel mapping wrong");
  cfg_read_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h15
      |-> reg_rdata == {dual_r, 2'h0, yuv_r, 4'h0})
    else $error("format register readback wrong");
  vsel_out_a: assert property (
    settled && vsel_r[1] |-> vertical_sync_output == (vsel_r[0]
      ? $past(separator_vsync, 3) : $past(vsync_pin, 3)))
    else $error("vsync override not followed");
endmodule : sdof_asserts

bind sync_detect_output_format sdof_asserts chk (.*);

`default_nettype wire

// >>> bench/sync_detect_output_format_tb.sv
/*
  Self-checking bench for the sync detect and output format block.
  Assumes the capture model and the bound checker are compiled.
*/
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module sync_detect_output_format_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, red_a, green_a, blue_a, red_b, green_b, blue_b;
  logic [7:0] cap_red, cap_green, cap_blue, pix = 8'h00, v;
  logic hsync_pin = 1'b0, vsync_pin = 1'b1, coast_pin = 1'b0;
  logic green_sync_slicer_input = 1'b0, separator_vsync = 1'b0;
  logic output_pixel_clock, vertical_sync_output;
  logic h_en = 1'b0, s_en = 1'b0, sep_en = 1'b0, v_en = 1'b0;
  logic c_en = 1'b0;
  logic [4:0] cyc = 5'h00;
  int checks = 0;
  int n_fail = 0;
  wire [7:0] red_in = pix;
  wire [7:0] green_in = pix + 8'h40;
  wire [7:0] blue_in = ~pix;

  sync_detect_output_format #(.WATCH_CYCLES(64)) dut (.*);
  pixel_capture cap (.*);

  always #2 core_clk = ~core_clk;

  // Sync trains: period 20, pulse 4
  always @(posedge core_clk) begin
    cyc <= (cyc == 5'h13) ? 5'h00 : cyc + 5'h01;
    pix <= pix + 8'h01;
    hsync_pin <= h_en && cyc < 5'h04;
    green_sync_slicer_input <= s_en && cyc < 5'h04;
    separator_vsync <= sep_en && cyc < 5'h04;
    coast_pin <= c_en && cyc < 5'h04;
    vsync_pin <= !(v_en && cyc < 5'h04);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic pix_chk(input logic yuv);
    logic [7:0] p, last_g;
    logic was_u, is_u;
    repeat (6) @(posedge core_clk);
    #1 last_g = cap_green;
    was_u = cap_red == ~(cap_green - 8'h40);
    repeat (12) begin
      @(posedge core_clk);
      #1 p = cap_green - 8'h40;
      is_u = cap_red == ~p;
      `CHK(cap_green, last_g + 8'h01)
      if (yuv) begin
        `CHK(is_u, !was_u)
        `CHK(cap_red, is_u ? ~p : p)
      end else begin
        `CHK(cap_red, p)
      end
      `CHK(cap_blue, yuv ? 8'h00 : ~p)
      last_g = cap_green;
      was_u = is_u;
    end
  endtask : pix_chk

  task automatic t_regs;
    rd(8'h15, v); `CHK(v, 8'h80)
    rd(8'h14, v); `CHK(v, 8'h0C)
    wr(8'h14, 8'hFF);
    rd(8'h14, v); `CHK(v, 8'h0C)
    rd(8'h20, v); `CHK(v, 8'h00)
    $display("test regs done");
  endtask : t_regs

  task automatic t_pixels;
    pix_chk(1'b0);
    wr(8'h15, 8'h00);
    pix_chk(1'b0);
    wr(8'h15, 8'h10);
    rd(8'h15, v); `CHK(v, 8'h10)
    pix_chk(1'b1);
    wr(8'h15, 8'h00);
    $display("test pixels done");
  endtask : t_pixels

  task automatic t_sync;
    h_en = 1'b1;
    sep_en = 1'b1;
    c_en = 1'b1;
    repeat (200) @(posedge core_clk);
    rd(8'h14, v); `CHK(v, 8'hA9)
    h_en = 1'b0;
    s_en = 1'b1;
    repeat (120) @(posedge core_clk);
    rd(8'h14, v); `CHK(v, 8'h6B)
    v_en = 1'b1;
    wr(8'h0F, 8'h20);
    repeat (200) @(posedge core_clk);
    rd(8'h14, v); `CHK(v, 8'h76)
    wr(8'h0E, 8'h1B);
    repeat (200) @(posedge core_clk);
    rd(8'h14, v); `CHK(v[3:2], 2'h0)
    rd(8'h0E, v); `CHK(v, 8'h1B)
    {s_en, sep_en, v_en, c_en} = 4'h0;
    repeat (120) @(posedge core_clk);
    rd(8'h14, v); `CHK({v[7], v[4], v[1]}, 3'h0)
    $display("test sync done");
  endtask : t_sync

  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_pixels();
    t_sync();
    end_sim();
  end

  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule : sync_detect_output_format_tb

`default_nettype wire

// >>> core/activity_watch.sv
/*
  Activity watchdog for one synchronised sync signal.
  Assumes the input is already in the core clock domain.
*/
`default_nettype none

module activity_watch #(
  parameter int WATCH_CYCLES = sync_fmt_pkg::WATCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic level,
  output logic active_r
);

  localparam logic [sync_fmt_pkg::ACT_CNT_W-1:0] LAST =
    sync_fmt_pkg::ACT_CNT_W'(WATCH_CYCLES - 1);

  logic prev_r;
  logic [1:0] arm_r;
  logic [sync_fmt_pkg::ACT_CNT_W-1:0] cnt_r;
  // Edges count only once the synchroniser holds a real sample
  wire logic armed = (arm_r == 2'h3);
  wire logic edge_seen = armed & (level ^ prev_r);
  wire logic expired = (cnt_r == LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
      arm_r <= 2'h0;
      cnt_r <= '0;
      active_r <= 1'b0;
    end else begin
      prev_r <= level;
      if (!armed) begin
        arm_r <= arm_r + 2'h1;
      end
      if (edge_seen) begin
        cnt_r <= '0;
        active_r <= 1'b1;
      end else if (expired) begin
        active_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule : activity_watch

`default_nettype wire

// >>> core/placeholder_none.sv
/*
  Intentionally empty compile unit kept out of the design.
  Assumes nothing.
*/
`default_nettype none
`default_nettype wire

// >>> core/polarity_sense.sv
/*
  Polarity sense for one periodic sync signal: a short high phase
  compared with the low phase means active high.
  Assumes the input is already in the core clock domain.
*/
`default_nettype none

module polarity_sense (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic level,
  output logic active_high_r
);

  localparam logic [sync_fmt_pkg::POL_CNT_W-1:0] CNT_MAX = '1;

  logic prev_r;
  logic [1:0] arm_r;
  logic [sync_fmt_pkg::POL_CNT_W-1:0] high_cnt_r;
  logic [sync_fmt_pkg::POL_CNT_W-1:0] low_cnt_r;
  // No false rise while the synchroniser fills after reset
  wire logic armed = (arm_r == 2'h3);
  wire logic rise = armed & level & ~prev_r;
  wire logic high_sat = (high_cnt_r == CNT_MAX);
  wire logic low_sat = (low_cnt_r == CNT_MAX);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
      arm_r <= 2'h0;
      high_cnt_r <= '0;
      low_cnt_r <= '0;
      active_high_r <= 1'b0;
    end else begin
      prev_r <= level;
      if (!armed) begin
        arm_r <= arm_r + 2'h1;
      end
      if (rise) begin
        // Decide once per period, then restart both counts
        active_high_r <= (high_cnt_r < low_cnt_r);
        high_cnt_r <= '0;
        low_cnt_r <= '0;
      end else if (level && !high_sat) begin
        high_cnt_r <= high_cnt_r + 1'b1;
      end else if (!level && !low_sat) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
    end
  end

endmodule : polarity_sense

`default_nettype wire

// >>> core/sync_detect_output_format.sv
/*
  Sync activity and polarity status plus output format for a
  three-channel video digitiser, with its register port.
  Assumes sync pins are asynchronous, pixel data arrive on core_clk
  at one pixel per cycle, and the register port is on core_clk.
*/
// Operation
// - Status bit 7 shows hsync pin activity
// - Status bit 6 shows automatic hsync source
// - Hsync override uses software source
// - Status bit 5 shows input hsync polarity
// - Status bit 4 shows vsync pin activity
// - Status bit 3 shows automatic vsync source
// - Status bit 2: vsync output polarity, 1=low
// - Status bit 1 shows slicer activity
// - Status bit 0 shows coast signal polarity
// - Dual channel mode, half-rate clock, resets dual
// - Config bit 4 selects 4:2:2, resets normal
// - 4:2:2: red carries chroma, green carries Y
// - Coast source: pin, or vsync when selected
`default_nettype none

module sync_detect_output_format #(
  parameter int WATCH_CYCLES = sync_fmt_pkg::WATCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [sync_fmt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sync_fmt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sync_fmt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic hsync_pin,
  input wire logic vsync_pin,
  input wire logic green_sync_slicer_input,
  input wire logic separator_vsync,
  input wire logic coast_pin,
  input wire logic [sync_fmt_pkg::PIX_W-1:0] red_in,
  input wire logic [sync_fmt_pkg::PIX_W-1:0] green_in,
  input wire logic [sync_fmt_pkg::PIX_W-1:0] blue_in,
  output logic [sync_fmt_pkg::PIX_W-1:0] red_a,
  output logic [sync_fmt_pkg::PIX_W-1:0] green_a,
  output logic [sync_fmt_pkg::PIX_W-1:0] blue_a,
  output logic [sync_fmt_pkg::PIX_W-1:0] red_b,
  output logic [sync_fmt_pkg::PIX_W-1:0] green_b,
  output logic [sync_fmt_pkg::PIX_W-1:0] blue_b,
  output logic output_pixel_clock,
  output logic vertical_sync_output
);

  localparam int PW = sync_fmt_pkg::PIX_W;
  localparam int NP = sync_fmt_pkg::PIN_COUNT;

  // Pin synchronisers
  wire logic [NP-1:0] pins_raw = {
    coast_pin, separator_vsync, green_sync_slicer_input,
    vsync_pin, hsync_pin
  };
  logic [NP-1:0] pins_meta_r;
  logic [NP-1:0] pins_sync_r;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          pins_meta_r[gi] <= 1'b0;
          pins_sync_r[gi] <= 1'b0;
        end else begin
          pins_meta_r[gi] <= pins_raw[gi];
          pins_sync_r[gi] <= pins_meta_r[gi];
        end
      end
    end
  endgenerate

  wire logic hs_s = pins_sync_r[sync_fmt_pkg::PIN_HSYNC];
  wire logic vs_s = pins_sync_r[sync_fmt_pkg::PIN_VSYNC];
  wire logic sl_s = pins_sync_r[sync_fmt_pkg::PIN_SLICER];
  wire logic sep_s = pins_sync_r[sync_fmt_pkg::PIN_SEPARATOR];
  wire logic co_s = pins_sync_r[sync_fmt_pkg::PIN_COAST];

  // Software registers
  logic h_override_r;
  logic h_source_r;
  logic v_override_r;
  logic v_source_r;
  logic coast_select_r;
  logic dual_channel_r;
  logic yuv_422_r;
  logic [sync_fmt_pkg::DATA_W-1:0] rdata_r;

  wire logic sel_override =
    (reg_addr == sync_fmt_pkg::ADDR_SOURCE_OVERRIDE);
  wire logic sel_coast = (reg_addr == sync_fmt_pkg::ADDR_COAST_CONTROL);
  wire logic sel_status =
    (reg_addr == sync_fmt_pkg::ADDR_SYNC_DETECT_STATUS);
  wire logic sel_format =
    (reg_addr == sync_fmt_pkg::ADDR_OUTPUT_FORMAT_CONFIG);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      h_override_r <= sync_fmt_pkg::SOURCE_OVERRIDE_RESET[
        sync_fmt_pkg::BIT_H_OVERRIDE];
      h_source_r <= sync_fmt_pkg::SOURCE_OVERRIDE_RESET[
        sync_fmt_pkg::BIT_H_SOURCE];
      v_override_r <= sync_fmt_pkg::SOURCE_OVERRIDE_RESET[
        sync_fmt_pkg::BIT_V_OVERRIDE];
      v_source_r <= sync_fmt_pkg::SOURCE_OVERRIDE_RESET[
        sync_fmt_pkg::BIT_V_SOURCE];
    end else if (reg_wr && sel_override) begin
      h_override_r <= reg_wdata[sync_fmt_pkg::BIT_H_OVERRIDE];
      h_source_r <= reg_wdata[sync_fmt_pkg::BIT_H_SOURCE];
      v_override_r <= reg_wdata[sync_fmt_pkg::BIT_V_OVERRIDE];
      v_source_r <= reg_wdata[sync_fmt_pkg::BIT_V_SOURCE];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      coast_select_r <= sync_fmt_pkg::COAST_SELECT_RESET;
    end else if (reg_wr && sel_coast) begin
      coast_select_r <= reg_wdata[sync_fmt_pkg::BIT_COAST_SELECT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dual_channel_r <= sync_fmt_pkg::DUAL_CHANNEL_RESET;
      yuv_422_r <= sync_fmt_pkg::YUV_422_RESET;
    end else if (reg_wr && sel_format) begin
      dual_channel_r <= reg_wdata[sync_fmt_pkg::BIT_DUAL_CHANNEL];
      yuv_422_r <= reg_wdata[sync_fmt_pkg::BIT_YUV_422];
    end
  end

  // Activity watchdogs: hsync pin, vsync pin, slicer
  wire logic [2:0] act_in = {sl_s, vs_s, hs_s};
  logic [2:0] act;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_act
      activity_watch #(
        .WATCH_CYCLES(WATCH_CYCLES)
      ) u_act (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .level(act_in[gi]),
        .active_r(act[gi])
      );
    end
  endgenerate

  wire logic h_active = act[0];
  wire logic v_active = act[1];
  wire logic slicer_active = act[2];

  wire logic auto_horizontal_source = ~h_active & slicer_active;
  wire logic auto_vertical_source = ~v_active;
  wire logic h_src = h_override_r ? h_source_r : auto_horizontal_source;
  wire logic v_src = v_override_r ? v_source_r : auto_vertical_source;

  wire logic hs_eff = h_src ? sl_s : hs_s;
  wire logic vs_eff = v_src ? sep_s : vs_s;
  wire logic coast_sig = coast_select_r ? vs_eff : co_s;

  // Polarity: hsync pin, vsync output, coast, selected hsync
  wire logic [3:0] pol_in = {hs_eff, coast_sig, vs_eff, hs_s};
  logic [3:0] pol;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_pol
      polarity_sense u_pol (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .level(pol_in[gi]),
        .active_high_r(pol[gi])
      );
    end
  endgenerate

  // Status word
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[sync_fmt_pkg::BIT_H_ACTIVE] = h_active;
    status[sync_fmt_pkg::BIT_H_AUTO_SRC] = auto_horizontal_source;
    status[sync_fmt_pkg::BIT_H_POLARITY] = pol[0];
    status[sync_fmt_pkg::BIT_V_ACTIVE] = v_active;
    status[sync_fmt_pkg::BIT_V_AUTO_SRC] = auto_vertical_source;
    status[sync_fmt_pkg::BIT_VOUT_POLARITY] = ~pol[1];
    status[sync_fmt_pkg::BIT_SLICER_ACTIVE] = slicer_active;
    status[sync_fmt_pkg::BIT_COAST_POLARITY] = pol[2];
  end

  wire logic [7:0] override_rd = {
    3'h0, h_override_r, h_source_r, 1'b0, v_override_r, v_source_r
  };
  wire logic [7:0] coast_rd = {2'h0, coast_select_r, 5'h00};
  wire logic [7:0] format_rd = {dual_channel_r, 2'h0, yuv_422_r, 4'h0};

  logic [7:0] rd_mux;
  always_comb begin
    if (sel_status) begin
      rd_mux = status;
    end else if (sel_format) begin
      rd_mux = format_rd;
    end else if (sel_override) begin
      rd_mux = override_rd;
    end else if (sel_coast) begin
      rd_mux = coast_rd;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Pixel phase, restarted at the leading edge of selected hsync
  logic hs_prev_r;
  logic phase_r;
  wire logic hs_lead = pol[3] ? (hs_eff & ~hs_prev_r) :
                                (~hs_eff & hs_prev_r);
  wire logic phase_nxt = hs_lead ? 1'b0 : ~phase_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_prev_r <= 1'b0;
      phase_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_eff;
      phase_r <= phase_nxt;
    end
  end

  // U from blue input, V from red input
  wire logic [PW-1:0] fmt_red = !yuv_422_r ? red_in :
                                 (phase_nxt ? red_in : blue_in);
  wire logic [PW-1:0] fmt_green = green_in;
  wire logic [PW-1:0] fmt_blue = yuv_422_r ? {PW{1'b0}} : blue_in;

  wire logic load_a = !dual_channel_r || !phase_nxt;
  wire logic load_b = dual_channel_r && phase_nxt;

  logic [PW-1:0] red_a_r;
  logic [PW-1:0] green_a_r;
  logic [PW-1:0] blue_a_r;
  logic [PW-1:0] red_b_r;
  logic [PW-1:0] green_b_r;
  logic [PW-1:0] blue_b_r;
  logic pclk_r;
  logic vertical_sync_output_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      red_a_r <= '0;
      green_a_r <= '0;
      blue_a_r <= '0;
    end else if (load_a) begin
      red_a_r <= fmt_red;
      green_a_r <= fmt_green;
      blue_a_r <= fmt_blue;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      red_b_r <= '0;
      green_b_r <= '0;
      blue_b_r <= '0;
    end else if (!dual_channel_r) begin
      red_b_r <= '0;
      green_b_r <= '0;
      blue_b_r <= '0;
    end else if (load_b) begin
      red_b_r <= fmt_red;
      green_b_r <= fmt_green;
      blue_b_r <= fmt_blue;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pclk_r <= 1'b0;
      vertical_sync_output_r <= 1'b0;
    end else begin
      pclk_r <= dual_channel_r ? ~phase_nxt : 1'b1;
      vertical_sync_output_r <= vs_eff;
    end
  end

  assign reg_rdata = rdata_r;
  assign red_a = red_a_r;
  assign green_a = green_a_r;
  assign blue_a = blue_a_r;
  assign red_b = red_b_r;
  assign green_b = green_b_r;
  assign blue_b = blue_b_r;
  assign output_pixel_clock = pclk_r;
  assign vertical_sync_output = vertical_sync_output_r;

endmodule : sync_detect_output_format

`default_nettype wire

// >>> pkg/sync_fmt_pkg.sv
/*
  Shared constants for the sync detect and output format block:
  register offsets, field positions, reset values and timing counts.
  Assumes an 8-bit register port and a 250 MHz core clock.
*/
`default_nettype none

package sync_fmt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIX_W = 8;

  // Register offsets
  localparam logic [7:0] ADDR_SOURCE_OVERRIDE = 8'h0E;
  localparam logic [7:0] ADDR_COAST_CONTROL = 8'h0F;
  localparam logic [7:0] ADDR_SYNC_DETECT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_OUTPUT_FORMAT_CONFIG = 8'h15;

  // Source override fields
  localparam int BIT_H_OVERRIDE = 4;
  localparam int BIT_H_SOURCE = 3;
  localparam int BIT_V_OVERRIDE = 1;
  localparam int BIT_V_SOURCE = 0;
  localparam logic [3:0] SOURCE_OVERRIDE_RESET = 4'h0;

  // Coast control field
  localparam int BIT_COAST_SELECT = 5;
  localparam logic COAST_SELECT_RESET = 1'b0;

  // Status fields
  localparam int BIT_H_ACTIVE = 7;
  localparam int BIT_H_AUTO_SRC = 6;
  localparam int BIT_H_POLARITY = 5;
  localparam int BIT_V_ACTIVE = 4;
  localparam int BIT_V_AUTO_SRC = 3;
  localparam int BIT_VOUT_POLARITY = 2;
  localparam int BIT_SLICER_ACTIVE = 1;
  localparam int BIT_COAST_POLARITY = 0;

  // Output format fields
  localparam int BIT_DUAL_CHANNEL = 7;
  localparam int BIT_YUV_422 = 4;
  localparam logic DUAL_CHANNEL_RESET = 1'b1;
  localparam logic YUV_422_RESET = 1'b0;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int WATCH_US = 100;
  localparam int WATCH_CYCLES = WATCH_US * CLK_MHZ;
  localparam int ACT_CNT_W = 24;
  localparam int POL_CNT_W = 16;

  // Synchronised pin indices
  localparam int PIN_HSYNC = 0;
  localparam int PIN_VSYNC = 1;
  localparam int PIN_SLICER = 2;
  localparam int PIN_SEPARATOR = 3;
  localparam int PIN_COAST = 4;
  localparam int PIN_COUNT = 5;

endpackage : sync_fmt_pkg

`default_nettype wire
